// ===== include/e1_tsc_map.vh
// register map, field positions and pattern constants of the e1 timeslot conditioning block
`ifndef E1_TSC_MAP_VH
`define E1_TSC_MAP_VH

// indirect indices as printed; byte address is four times the index
`define TSC_IDX_CTRL_BASE     7'h00
`define TSC_IDX_CODE_BASE     7'h20
`define TSC_IDX_SIG_LO_FIRST  7'h41
`define TSC_IDX_SIG_LO_LAST   7'h4f
`define TSC_IDX_SIG_HI_FIRST  7'h51
`define TSC_IDX_SIG_HI_LAST   7'h5f
// global configuration and status words
`define TSC_IDX_GLOBAL        7'h60
`define TSC_IDX_STATUS        7'h61

// slot control word fields
`define TSC_CTRL_REPL_HI      7
`define TSC_CTRL_REPL_LO      5
`define TSC_CTRL_MSB_INV      4
`define TSC_CTRL_ODD_INV      3
`define TSC_CTRL_EVEN_INV     2
`define TSC_CTRL_LSB_HOLD     1
`define TSC_CTRL_SLOT_HOLD    0

// signaling code word fields
`define TSC_SIG_TEST          6
`define TSC_SIG_ENABLE        4
`define TSC_SIG_WMASK         8'h5f

// global word fields
`define TSC_GLB_REPL_HI       2
`define TSC_GLB_REPL_LO       0
`define TSC_GLB_SIG_EN        3
`define TSC_GLB_HOLD_EN       4
`define TSC_GLB_DIR           5
`define TSC_GLB_WMODE_HI      7
`define TSC_GLB_WMODE_LO      6
`define TSC_GLB_WMASK         32'h0000_00ff

// replacement selections
`define TSC_REPL_NONE         3'h0
`define TSC_REPL_CODE         3'h1
`define TSC_REPL_ALAW         3'h2
`define TSC_REPL_ULAW         3'h3
`define TSC_REPL_LOOP         3'h4

// pattern width modes
`define TSC_WMODE_8BIT        2'h1
`define TSC_WMODE_7BIT        2'h2

// inversion masks, bit 1 of the slot is data bit 7
`define TSC_MASK_EVEN         8'h55
`define TSC_MASK_ODD          8'h2a
`define TSC_MASK_MSB          8'h80

// milliwatt sequences, eight bytes each, first byte in the low lane
`define TSC_ALAW_SEQ          64'hb4a1a1b4_3421_2134
`define TSC_ULAW_SEQ          64'h9e8b8b9e_1e0b_0b1e

`define TSC_LAST_SLOT         5'h1f
`define TSC_SIG_SLOT          5'h10

`endif

// ===== verilog/e1_timeslot_conditioning.v
// e1 per-timeslot payload conditioning with an axi4-lite register slave
//
// Operation
// - slot test bit needs 8- or 7-bit mode
// - test bit, direction 0 extracts to detector
// - test bit, direction 1 inserts generator data
// - 8-bit mode all bits, 7-bit seven msbs
// - test bit 0 keeps slot out of pattern
// - extracted slots form one continuous stream
// - inserted slots consume one continuous sequence
// - slot enable replaces signaling with stored code
// - global or slot enable applies signaling code
// - signaling entries at 0x41-0x4f, 0x51-0x5f
// - slot control entries at 0x00-0x1f
// - data code entries at 0x20-0x3f
// - slot select only when global select 000
// - codes none, stored, a-law, mu-law
// - code 100 takes receive loopback data
// - even, odd, msb inversions combine
// - gapping only clock master and enabled
// - lsb gap bit 8, slot gap whole
// - stored code on global or slot select
//
// word map, byte address is four times the index:
//   0x00-0x1f  slot control: [7:5] replace select, [4] msb invert,
//              [3] odd invert, [2] even invert, [1] bit 8 gap, [0] slot gap
//   0x20-0x3f  stored data code, one byte per slot
//   0x41-0x4f, 0x51-0x5f  signaling word: [6] test, [4] enable, [3:0] code;
//              bits 7 and 5 always read zero
//   0x60       global: [2:0] replace select, [3] signaling enable,
//              [4] gap enable, [5] pattern direction, [7:6] width mode
//              (01 is 8-bit, 10 is 7-bit, others ignore the test bits)
//   0x61       status, read only: [10:8] milliwatt phase, [4:0] last slot
// index 0x40, 0x50 and any unused index answer slverr and store nothing
//
// slot stream: a byte is taken on an edge with slot_strobe high; every
// conditioned output follows one cycle later with out_strobe; the
// strobes stand one cycle, data, signaling and gap until the next slot
// prbs_gen_take asks the generator for prbs_gen_bits bits and
// prbs_chk_valid hands the detector the prbs_chk_bits msbs of
// prbs_chk_data; unselected slots leave both low, which is what joins
// the selected slots into one continuous stream
//
// register bus: awready and wready pulse a cycle after their valid,
// bvalid follows the later handshake by two cycles; arready pulses a
// cycle after arvalid, rvalid and data one cycle later; both answers
// stand until taken
// reset clears every entry and output; a request may come on the first
// edge after release
//
// order inside a slot: replacement, inversion, pattern insertion;
// extraction taps the raw byte, before any conditioning
//
// limitations:
//   only byte lane 0 is used; wstrb[0] low answers okay, stores nothing
//   a bank write landing on a slot's strobe edge is seen from that
//   slot's next pass, so a byte never mixes old and new settings
//   pattern generator, detector, bit clock gating and the receive
//   side banks are outside this block
//
// The AXI4-Lite slave port was chosen for this implementation.
`include "e1_tsc_map.vh"

module e1_timeslot_conditioning #(
    parameter SLOTS = 32
) (
    input  wire        clk_sys,
    input  wire        rstn,
    // axi4-lite slave
    input  wire [8:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [8:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // framer slot stream
    input  wire        slot_strobe,
    input  wire [4:0]  slot_count,
    input  wire [7:0]  slot_data,
    input  wire [3:0]  slot_signaling,
    input  wire [7:0]  loopback_data,
    input  wire        tx_clock_master,
    // pattern generator byte, next bits of its sequence, msb first
    input  wire [7:0]  prbs_gen_data,
    // conditioned slot out
    output reg         out_strobe,
    output reg  [4:0]  out_count,
    output reg  [7:0]  out_data,
    output reg  [3:0]  out_signaling,
    output reg         gap_bit8,
    output reg         gap_slot,
    // generator consumption and detector feed
    output reg         prbs_gen_take,
    output reg  [3:0]  prbs_gen_bits,
    output reg         prbs_chk_valid,
    output reg  [7:0]  prbs_chk_data,
    output reg  [3:0]  prbs_chk_bits
);

    // per-slot banks
    reg [7:0]  slot_ctrl [0:SLOTS-1];
    reg [7:0]  slot_code [0:SLOTS-1];
    reg [7:0]  slot_sig  [0:SLOTS-1];
    reg [7:0]  global_cfg;
    reg [2:0]  mw_phase;
    integer    i;

    // global fields
    wire [2:0] global_replace_select  = global_cfg[`TSC_GLB_REPL_HI:`TSC_GLB_REPL_LO];
    wire       global_sig_cond_enable = global_cfg[`TSC_GLB_SIG_EN];
    wire       clock_hold_enable      = global_cfg[`TSC_GLB_HOLD_EN];
    wire       pattern_direction      = global_cfg[`TSC_GLB_DIR];
    wire [1:0] pattern_width_mode     = global_cfg[`TSC_GLB_WMODE_HI:`TSC_GLB_WMODE_LO];

    // axi write channel holding
    reg        aw_held;
    reg        w_held;
    reg [6:0]  aw_index;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    wire       do_write = aw_held && w_held && !s_axi_bvalid;

    // index decode for a write; signaling slots 0 and 16 have no entry
    wire       wr_ctrl = (aw_index[6:5] == 2'b00);
    wire       wr_code = (aw_index[6:5] == 2'b01);
    wire       wr_sig  = (aw_index[6:5] == 2'b10) && (aw_index[3:0] != 4'h0);
    // status index is read only, so a write to it falls to slverr
    wire       wr_glb  = (aw_index == `TSC_IDX_GLOBAL);
    // mapped when the index hits a bank or the global word
    wire       wr_mapped = wr_ctrl || wr_code || wr_sig || wr_glb;

    // accept address and data in either order, answer once both are in;
    // ready is a one-cycle pulse, so a held half is never taken twice and
    // a new write waits until the pending response has been collected
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_index      <= 7'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held  <= 1'b1;
                aw_index <= s_axi_awaddr[8:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unmapped index answers slverr and writes nothing
                s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register storage; only byte lane 0 carries data
    // reset clears every entry, so an unconfigured line passes untouched
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < SLOTS; i = i + 1) begin
                slot_ctrl[i] <= 8'h00;
                slot_code[i] <= 8'h00;
                slot_sig[i]  <= 8'h00;
            end
            global_cfg <= 8'h00;
        end else if (do_write && w_strb[0]) begin
            if (wr_ctrl)
                slot_ctrl[aw_index[4:0]] <= w_data[7:0];
            if (wr_code)
                slot_code[aw_index[4:0]] <= w_data[7:0];
            // reserved bits 7 and 5 stay zero
            if (wr_sig)
                slot_sig[aw_index[4:0]] <= w_data[7:0] & `TSC_SIG_WMASK;
            if (wr_glb)
                global_cfg <= w_data[7:0];
        end
    end

    // status word: milliwatt phase and the last slot count sent out
    wire [31:0] status_word = {21'h0, mw_phase, 3'h0, out_count};

    // read decode; sampled on the address handshake, so a read shows
    // the banks as they stand in that cycle
    reg [31:0] rd_word;
    reg        rd_ok;
    wire [6:0] ar_index = s_axi_araddr[8:2];
    always @* begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (ar_index[6:5])
            2'b00: rd_word = {24'h000000, slot_ctrl[ar_index[4:0]]};
            2'b01: rd_word = {24'h000000, slot_code[ar_index[4:0]]};
            2'b10: begin
                // 0x40 and 0x50 would be slots 0 and 16, which have none
                if (ar_index[3:0] != 4'h0)
                    rd_word = {24'h000000, slot_sig[ar_index[4:0]]};
                else
                    rd_ok = 1'b0;
            end
            // above the signaling bank: global word, status word or nothing
            default: begin
                if (ar_index == `TSC_IDX_GLOBAL)
                    rd_word = {24'h000000, global_cfg};
                else if (ar_index == `TSC_IDX_STATUS)
                    rd_word = status_word;
                else
                    rd_ok = 1'b0;
            end
        endcase
    end

    // read channel: one address at a time, data the cycle after the handshake
    // arready waits for rvalid to clear, so one read at most is in flight
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ---------------- slot datapath ----------------

    // look up the current slot's entries by framer count
    wire [7:0] cur_ctrl = slot_ctrl[slot_count];
    wire [7:0] cur_code = slot_code[slot_count];
    wire [7:0] cur_sig  = slot_sig[slot_count];
    // slots 0 and 16 carry alignment and multiframe signaling
    wire       sig_slot = (slot_count != 5'h00) && (slot_count != `TSC_SIG_SLOT);

    // slot select only while the global select is zero
    wire [2:0] eff_select = (global_replace_select == `TSC_REPL_NONE) ?
                            cur_ctrl[`TSC_CTRL_REPL_HI:`TSC_CTRL_REPL_LO] :
                            global_replace_select;

    // milliwatt bytes for the current frame phase
    // both sequences are eight bytes long, so one phase counter serves both
    wire [63:0] alaw_seq  = `TSC_ALAW_SEQ;
    wire [63:0] ulaw_seq  = `TSC_ULAW_SEQ;
    wire [7:0]  alaw_byte = alaw_seq[{mw_phase, 3'b000} +: 8];
    wire [7:0]  ulaw_byte = ulaw_seq[{mw_phase, 3'b000} +: 8];

    // the loopback byte must already be aligned to this slot by the framer
    // replacement selection; reserved codes leave data alone
    reg [7:0] repl_data;
    always @* begin
        case (eff_select)
            `TSC_REPL_CODE: repl_data = cur_code;
            `TSC_REPL_ALAW: repl_data = alaw_byte;
            `TSC_REPL_ULAW: repl_data = ulaw_byte;
            `TSC_REPL_LOOP: repl_data = loopback_data;
            default:        repl_data = slot_data;
        endcase
    end

    wire [7:0] inv_mask = (cur_ctrl[`TSC_CTRL_EVEN_INV] ? `TSC_MASK_EVEN : 8'h00) |
                          (cur_ctrl[`TSC_CTRL_ODD_INV]  ? `TSC_MASK_ODD  : 8'h00) |
                          (cur_ctrl[`TSC_CTRL_MSB_INV]  ? `TSC_MASK_MSB  : 8'h00);
    // inversion acts on a replaced byte too, so a stored code goes out inverted
    wire [7:0] cond_data = repl_data ^ inv_mask;

    // test bit honoured only in a per-slot width mode
    wire mode8     = (pattern_width_mode == `TSC_WMODE_8BIT);
    wire mode7     = (pattern_width_mode == `TSC_WMODE_7BIT);
    // slots 0 and 16 have no signaling word, so they never join the test
    // unselected slots stay out of the pattern path
    wire test_slot = cur_sig[`TSC_SIG_TEST] && sig_slot && (mode8 || mode7);
    wire do_chk    = test_slot && !pattern_direction;
    wire do_ins    = test_slot && pattern_direction;

    // in 7-bit mode the pattern owns only the seven msbs of the slot
    // 7-bit mode keeps the lsb of the conditioned byte
    wire [7:0] ins_data = mode8 ? prbs_gen_data : {prbs_gen_data[7:1], cond_data[0]};

    // the global enable reaches every slot that has a signaling word
    // global or slot signaling enable
    wire sig_apply = sig_slot && (global_sig_cond_enable || cur_sig[`TSC_SIG_ENABLE]);

    // gap outputs are levels for the slot; bit clock gating sits outside
    // gapping needs clock master mode and the global enable
    wire gap_ok = tx_clock_master && clock_hold_enable;

    // registered slot outputs; settings are sampled on the slot's strobe
    // every output is a flop, so each slot answers with the same lag
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            out_strobe     <= 1'b0;
            out_count      <= 5'h00;
            out_data       <= 8'h00;
            out_signaling  <= 4'h0;
            gap_bit8       <= 1'b0;
            gap_slot       <= 1'b0;
            prbs_gen_take  <= 1'b0;
            prbs_gen_bits  <= 4'h0;
            prbs_chk_valid <= 1'b0;
            prbs_chk_data  <= 8'h00;
            prbs_chk_bits  <= 4'h0;
            mw_phase       <= 3'h0;
        end else begin
            out_strobe     <= slot_strobe;
            prbs_gen_take  <= 1'b0;
            prbs_chk_valid <= 1'b0;
            if (slot_strobe) begin
                out_count <= slot_count;
                // generator bits overwrite the conditioned byte
                out_data  <= do_ins ? ins_data : cond_data;
                // stored signaling code replaces the slot's bits
                out_signaling <= sig_apply ? cur_sig[3:0] : slot_signaling;
                // slot gap overrides the bit 8 gap
                gap_slot <= gap_ok && cur_ctrl[`TSC_CTRL_SLOT_HOLD];
                gap_bit8 <= gap_ok && cur_ctrl[`TSC_CTRL_LSB_HOLD] &&
                            !cur_ctrl[`TSC_CTRL_SLOT_HOLD];
                // the generator advances only on inserted slots
                prbs_gen_take <= do_ins;
                prbs_gen_bits <= mode8 ? 4'h8 : 4'h7;
                // only extracted slots reach the detector, back to back
                prbs_chk_valid <= do_chk;
                prbs_chk_data  <= slot_data;
                prbs_chk_bits  <= mode8 ? 4'h8 : 4'h7;
                // milliwatt phase steps once per frame
                // and wraps after eight frames, in step with the sequences
                if (slot_count == `TSC_LAST_SLOT)
                    mw_phase <= mw_phase + 3'h1;
            end
        end
    end

endmodule // e1_timeslot_conditioning

// ===== sim/e1_tsc_props.sv
// concurrent checks on the ports of the e1 timeslot conditioning block
module e1_tsc_props (
    input wire       clk_sys,
    input wire       rstn,
    input wire       slot_strobe,
    input wire [4:0] slot_count,
    input wire [7:0] slot_data,
    input wire [3:0] slot_signaling,
    input wire       tx_clock_master,
    input wire       out_strobe,
    input wire [4:0] out_count,
    input wire [3:0] out_signaling,
    input wire       gap_bit8,
    input wire       gap_slot,
    input wire       prbs_gen_take,
    input wire [3:0] prbs_gen_bits,
    input wire       prbs_chk_valid,
    input wire [7:0] prbs_chk_data,
    input wire       s_axi_arvalid,
    input wire       s_axi_arready,
    input wire       s_axi_rvalid,
    input wire       s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // a slot byte taken, and a read address taken
    sequence s_slot_in;
        slot_strobe;
    endsequence
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_SLOT_ECHO: assert property (s_slot_in |=> out_strobe && out_count == $past(slot_count))
        else $error("slot answer missing or count wrong");
    AST_NO_SPURIOUS: assert property (!slot_strobe |=> !out_strobe)
        else $error("slot answer without a slot");
    AST_GAP_SLAVE: assert property (s_slot_in ##0 !tx_clock_master |=> !gap_bit8 && !gap_slot)
        else $error("gap raised outside clock master mode");
    // slots 0 and 16 keep signaling
    AST_SIG_FIXED: assert property (s_slot_in ##0 (slot_count == 5'h00 || slot_count == 5'h10)
        |=> out_signaling == $past(slot_signaling))
        else $error("signaling changed on slot 0 or 16");
    AST_CHK_RAW: assert property (prbs_chk_valid |-> $past(slot_strobe) && prbs_chk_data == $past(slot_data))
        else $error("detector byte differs from slot byte");
    AST_ONE_WAY: assert property (prbs_chk_valid |-> !prbs_gen_take)
        else $error("extraction and insertion together");
    AST_GEN_WIDTH: assert property (prbs_gen_take |-> out_strobe && (prbs_gen_bits == 4'h8 || prbs_gen_bits == 4'h7))
        else $error("generator take with bad width or no slot");
    AST_READ_ANSWER: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped early");
endmodule // e1_tsc_props

bind e1_timeslot_conditioning e1_tsc_props u_props (.*);

// ===== sim/e1_timeslot_conditioning_bench.sv
// self-checking bench for the e1 timeslot conditioning block
`include "e1_tsc_map.vh"
module e1_timeslot_conditioning_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, slot_strobe, tx_clock_master, out_strobe, gap_bit8, gap_slot;
    logic        prbs_gen_take, prbs_chk_valid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb, slot_signaling, out_signaling, prbs_gen_bits, prbs_chk_bits;
    logic [4:0]  slot_count, out_count;
    logic [7:0]  slot_data, loopback_data, prbs_gen_data, out_data, prbs_chk_data;
    logic [8:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    int          n_mismatch, checks_done, i;
    logic [7:0]  e;
    // expected bytes per replacement select 0..5, data 99, code 3c, loopback 66
    logic [7:0]  rep_exp [0:5] = '{8'h99, 8'h3c, 8'h34, 8'h1e, 8'h66, 8'h99};
    logic [7:0]  pg [0:5] = '{8'h40, 8'h80, 8'h00, 8'hc0, 8'h60, 8'ha0};
    logic [7:0]  po [0:5] = '{8'h5a, 8'h5a, 8'h5a, 8'h5a, 8'hc3, 8'hc2};

    e1_timeslot_conditioning uut (.*);

    // 40 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask

    // write with address and data offered together, bready held until bvalid
    task wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr <= {a, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // no local limit: only the watchdog ends a wait without answer
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", r, s_axi_bresp);
    endtask

    task rd(input logic [6:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= {a, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", d, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
    endtask

    // one slot byte in; outputs are read at the falling edge after the answer
    task sl(input logic [4:0] c, input logic [7:0] d, input logic [3:0] s, input logic [7:0] g);
        @(posedge clk_sys);
        slot_strobe <= 1'b1;
        slot_count <= c;
        slot_data <= d;
        slot_signaling <= s;
        loopback_data <= 8'h66;
        prbs_gen_data <= g;
        @(posedge clk_sys);
        slot_strobe <= 1'b0;
        @(negedge clk_sys);
        chk("out_strobe", 32'h1, out_strobe);
        chk("out_count", c, out_count);
    endtask

    task stop_test;
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        n_mismatch++;
        stop_test;
    end

    initial begin
        rstn = 1'b0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {slot_strobe, tx_clock_master, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {slot_count, slot_data, slot_signaling, loopback_data, prbs_gen_data} = '0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(7'h05, 32'h0, 2'h0);
        rd(7'h25, 32'h0, 2'h0);
        rd(7'h41, 32'h0, 2'h0);
        wr(7'h1f, 32'hff, 2'h0);
        rd(7'h1f, 32'hff, 2'h0);
        wr(7'h3f, 32'ha5, 2'h0);
        rd(7'h3f, 32'ha5, 2'h0);
        wr(7'h4f, 32'hff, 2'h0);
        rd(7'h4f, 32'h5f, 2'h0);
        wr(7'h40, 32'h1f, 2'h2);
        rd(7'h40, 32'h0, 2'h2);
        wr(7'h50, 32'h1f, 2'h2);
        wr(`TSC_IDX_STATUS, 32'h0, 2'h2);
        s_axi_wstrb <= 4'he;
        wr(7'h1f, 32'h00, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd(7'h1f, 32'hff, 2'h0);
        $display("test registers done");
        // milliwatt phase stays at its first byte until slot 31 passes
        wr(7'h23, 32'h3c, 2'h0);
        for (i = 0; i < 6; i++) begin
            wr(7'h03, 32'(i) << 5, 2'h0);
            sl(5'h03, 8'h99, 4'h0, 8'h00);
            chk("out_data", rep_exp[i], out_data);
        end
        wr(`TSC_IDX_GLOBAL, 32'h1, 2'h0);
        sl(5'h03, 8'h99, 4'h0, 8'h00);
        chk("out_data", 8'h3c, out_data);
        wr(`TSC_IDX_GLOBAL, 32'h0, 2'h0);
        // slot 31 ends the frame: phase 1 picks the second a-law byte
        sl(5'h1f, 8'h99, 4'h0, 8'h00);
        chk("out_data", 8'h66, out_data);
        rd(`TSC_IDX_STATUS, 32'h11f, 2'h0);
        wr(7'h03, 32'h40, 2'h0);
        sl(5'h03, 8'h99, 4'h0, 8'h00);
        chk("out_data", 8'h21, out_data);
        $display("test replacement done");
        for (i = 0; i < 8; i++) begin
            wr(7'h02, 32'(i) << 2, 2'h0);
            sl(5'h02, 8'h0f, 4'h0, 8'h00);
            e = 8'h0f ^ (i[0] ? 8'h55 : 8'h00) ^ (i[1] ? 8'h2a : 8'h00) ^ (i[2] ? 8'h80 : 8'h00);
            chk("out_data", e, out_data);
        end
        $display("test inversion done");
        wr(`TSC_IDX_GLOBAL, 32'h10, 2'h0);
        for (i = 0; i < 8; i++) begin
            tx_clock_master <= i[2];
            wr(7'h04, 32'(i[1:0]), 2'h0);
            sl(5'h04, 8'h00, 4'h0, 8'h00);
            chk("gap_slot", i[2] & i[0], gap_slot);
            chk("gap_bit8", i[2] & i[1] & !i[0], gap_bit8);
        end
        wr(`TSC_IDX_GLOBAL, 32'h0, 2'h0);
        sl(5'h04, 8'h00, 4'h0, 8'h00);
        chk("gap_slot", 32'h0, gap_slot);
        $display("test gapping done");
        wr(7'h45, 32'h1a, 2'h0);
        sl(5'h05, 8'h00, 4'h3, 8'h00);
        chk("out_signaling", 4'ha, out_signaling);
        wr(7'h45, 32'h0a, 2'h0);
        sl(5'h05, 8'h00, 4'h3, 8'h00);
        chk("out_signaling", 4'h3, out_signaling);
        wr(`TSC_IDX_GLOBAL, 32'h08, 2'h0);
        sl(5'h05, 8'h00, 4'h3, 8'h00);
        chk("out_signaling", 4'ha, out_signaling);
        sl(5'h10, 8'h00, 4'h3, 8'h00);
        chk("out_signaling", 4'h3, out_signaling);
        $display("test signaling done");
        wr(7'h46, 32'h40, 2'h0);
        for (i = 0; i < 6; i++) begin
            wr(`TSC_IDX_GLOBAL, {24'h0, pg[i]}, 2'h0);
            sl(5'h06, 8'h5a, 4'h0, 8'hc3);
            chk("out_data", po[i], out_data);
            chk("prbs_chk_valid", i < 2, prbs_chk_valid);
            chk("prbs_gen_take", i > 3, prbs_gen_take);
            if (i < 2) chk("prbs_chk_data", 8'h5a, prbs_chk_data);
            if (i < 2) chk("prbs_chk_bits", i[0] ? 4'h7 : 4'h8, prbs_chk_bits);
            if (i > 3) chk("prbs_gen_bits", i[0] ? 4'h7 : 4'h8, prbs_gen_bits);
        end
        sl(5'h07, 8'h5a, 4'h0, 8'hc3);
        chk("out_data", 8'h5a, out_data);
        chk("prbs_gen_take", 32'h0, prbs_gen_take);
        $display("test pattern done");
        stop_test;
    end
endmodule // e1_timeslot_conditioning_bench
